/* dv/access_map_chk.sv */
// Concurrent checks on the link between the core end and the checker end
`timescale 1ns/100ps
module access_map_chk
   import access_map_pkg::*;
(
   // Clock and reset
   input wire logic  clk,
   input wire logic  rst,
   // Fetch side
   input wire logic  fetch_req,
   input wire addr_t fetch_addr,
   input wire logic  fetch_ack,
   input wire logic  fetch_allowed,
   input wire logic  fetch_in_itcm,
   input wire logic  fetch_cacheable,
   // Data side
   input wire logic  data_req,
   input wire addr_t data_addr,
   input wire logic  data_ack,
   input wire logic  data_allowed,
   input wire logic  data_in_dtcm,
   input wire logic  data_in_irq_ctrl,
   // Build status
   input wire logic  cfg_error,
   input wire logic  icache_present,
   input wire logic  icache_protection_select
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_fetch_ack_follows: assert property (fetch_req |=> fetch_ack)
      else $error("fetch request not answered next cycle");
   a_fetch_ack_cause: assert property (fetch_ack |-> $past(fetch_req))
      else $error("fetch answer without request");
   a_data_ack_follows: assert property (data_req |=> data_ack)
      else $error("data request not answered next cycle");
   a_data_ack_cause: assert property (data_ack |-> $past(data_req))
      else $error("data answer without request");
   a_fetch_result_hold: assert property (
      !fetch_ack |-> $stable({fetch_allowed, fetch_in_itcm, fetch_cacheable}))
      else $error("fetch result moved without answer");
   a_itcm_decode_hit: assert property (
      fetch_req |=> fetch_in_itcm == (($past(fetch_addr) >> 16) == 32'h0000_e000))
      else $error("instruction memory decode wrong");
   a_cacheable_rule_ok: assert property (
      fetch_ack |-> fetch_cacheable == (icache_present && fetch_allowed && !fetch_in_itcm))
      else $error("cacheable flag wrong");
   a_data_window_hit: assert property (
      data_req |=> data_allowed == ($past(data_addr) < 32'h9000_0000))
      else $error("data window decision wrong");
   a_dtcm_decode_hit: assert property (
      data_req |=> data_in_dtcm == (($past(data_addr) >> 16) == 32'h0000_f004))
      else $error("data memory decode wrong");
   a_irq_decode_hit: assert property (
      data_req |=> data_in_irq_ctrl == (($past(data_addr) >> 15) == 32'h0001_e180))
      else $error("interrupt block decode wrong");
   a_build_status_ok: assert property (
      !$past(rst) |-> !cfg_error && icache_present && !icache_protection_select)
      else $error("build status wrong");

   cover property (fetch_req && data_req);
   cover property (data_ack && data_in_dtcm);
   cover property (fetch_ack && fetch_in_itcm);
endmodule

/* dv/access_map_tb_top.sv */
// Testbench: core end and checker end joined, driven over AHB-Lite
`timescale 1ns/100ps
module access_map_tb_top;
   import access_map_pkg::*;
   typedef struct {logic kind; logic [31:0] addr; logic [3:0] exp;} row_t;
   logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, st;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          miscompares, total_checks, cycles;
   row_t        rows [14];

   access_if link ();
   access_map_device access_map_device_i (.clk(clk), .rst(rst), .bus(link));
   access_map_core access_map_core_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus(link));
   access_map_chk access_map_chk_i (.clk(clk), .rst(rst), .fetch_req(link.fetch_req),
      .fetch_addr(link.fetch_addr), .fetch_ack(link.fetch_ack),
      .fetch_allowed(link.fetch_allowed), .fetch_in_itcm(link.fetch_in_itcm),
      .fetch_cacheable(link.fetch_cacheable), .data_req(link.data_req),
      .data_addr(link.data_addr), .data_ack(link.data_ack), .data_allowed(link.data_allowed),
      .data_in_dtcm(link.data_in_dtcm), .data_in_irq_ctrl(link.data_in_irq_ctrl),
      .cfg_error(link.cfg_error), .icache_present(link.icache_present),
      .icache_protection_select(link.icache_protection_select));
   assign hready = hreadyout;

   // Misaligned fetch base and ECC protection; must raise the build error
   access_if bad_link ();
   access_map_device #(
      .FETCH_WIN_BASE ({{7{32'h0000_0000}}, 32'h0000_0010}),
      .ICACHE_ECC     (1'b1)
   ) bad_access_map_device_i (.clk(clk), .rst(rst), .bus(bad_link));
   assign {bad_link.fetch_req, bad_link.fetch_addr, bad_link.data_req, bad_link.data_addr,
           bad_link.data_write} = '0;

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One single AHB-Lite transfer, address phase then data phase
   task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, ofs};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel   <= 1'b0;
   endtask

   // Poll status until the given kinds are done and idle
   task automatic wait_done(input logic [12:0] need);
      logic fin;
      fin = 1'b0;
      while (!fin) begin
         ahb(1'b0, STATUS_OFS, 32'h0, st);
         fin = ((st[12:0] & need) === (need & 13'h0011));
      end
   endtask

   initial begin
      rows = '{'{1'b0, 32'he000_0000, 4'h7}, '{1'b0, 32'he000_fffc, 4'h7},
               '{1'b0, 32'he001_0000, 4'hb}, '{1'b0, 32'h0000_0040, 4'hb},
               '{1'b1, 32'h7fff_fffc, 4'h3}, '{1'b1, 32'h8000_0000, 4'h3},
               '{1'b1, 32'h8fff_fffc, 4'h3}, '{1'b1, 32'h9000_0000, 4'h1},
               '{1'b1, 32'hf003_fffc, 4'h1}, '{1'b1, 32'hf004_0000, 4'h5},
               '{1'b1, 32'hf004_fffc, 4'h5}, '{1'b1, 32'hf005_0000, 4'h1},
               '{1'b1, 32'hf0c0_7ffc, 4'h9}, '{1'b1, 32'hf0c0_8000, 4'h1}};
      {hsel, hwrite, haddr, htrans, hwdata} = '0;
      hsize = 3'b010;
      rst   = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      ahb(1'b0, STATUS_OFS, 32'h0, st);
      chk("status after reset", 32'h0000_0200, st);
      chk("bad build", 32'h0000_0003,
          {30'h0, bad_link.cfg_error, bad_link.icache_protection_select});
      ahb(1'b1, STATUS_OFS, 32'hffff_ffff, st);
      ahb(1'b0, STATUS_OFS, 32'h0, st);
      chk("status read only", 32'h0000_0200, st);
      ahb(1'b0, 8'h10, 32'h0, st);
      chk("unmapped read", 32'h0, st);
      foreach (rows[i]) begin
         ahb(1'b1, rows[i].kind ? DATA_ADDR_OFS : FETCH_ADDR_OFS, rows[i].addr, st);
         ahb(1'b1, CMD_OFS, rows[i].kind ? 32'h2 : 32'h1, st);
         wait_done(rows[i].kind ? 13'h1010 : 13'h0801);
         chk("decision", 32'(rows[i].exp), 32'(rows[i].kind ? st[7:4] : st[3:0]));
      end
      // Both kinds issued together with the write flag
      ahb(1'b1, FETCH_ADDR_OFS, 32'he000_0000, st);
      ahb(1'b1, DATA_ADDR_OFS, 32'hf0c0_0000, st);
      ahb(1'b1, CMD_OFS, 32'h7, st);
      wait_done(13'h1811);
      chk("both kinds", 32'h0000_0297, {19'h0, st[12:0]});
      ahb(1'b0, CMD_OFS, 32'h0, st);
      chk("write flag", 32'h1, {31'h0, st[2]});
      ahb(1'b0, FETCH_ADDR_OFS, 32'h0, st);
      chk("fetch address", 32'he000_0000, st);
      // Reset in mid-run
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      ahb(1'b0, STATUS_OFS, 32'h0, st);
      chk("status after second reset", 32'h0000_0200, st);
      ahb(1'b0, DATA_ADDR_OFS, 32'h0, st);
      chk("data address after reset", 32'h0, st);
      wrap_up();
   end
endmodule

/* src/access_if.sv */
// Interface between the access checker and the core fetch/load-store side
`timescale 1ns/100ps
interface access_if;
   import access_map_pkg::*;

   logic  fetch_req;
   addr_t fetch_addr;
   logic  fetch_ack;
   logic  fetch_allowed;
   logic  fetch_in_itcm;
   logic  fetch_cacheable;
   logic  data_req;
   addr_t data_addr;
   logic  data_write;
   logic  data_ack;
   logic  data_allowed;
   logic  data_in_dtcm;
   logic  data_in_irq_ctrl;
   logic  cfg_error;
   logic  icache_present;
   logic  icache_protection_select;

   modport device (
      input  fetch_req, fetch_addr, data_req, data_addr, data_write,
      output fetch_ack, fetch_allowed, fetch_in_itcm, fetch_cacheable,
      output data_ack, data_allowed, data_in_dtcm, data_in_irq_ctrl,
      output cfg_error, icache_present, icache_protection_select
   );

   modport core (
      output fetch_req, fetch_addr, data_req, data_addr, data_write,
      input  fetch_ack, fetch_allowed, fetch_in_itcm, fetch_cacheable,
      input  data_ack, data_allowed, data_in_dtcm, data_in_irq_ctrl,
      input  cfg_error, icache_present, icache_protection_select
   );
endinterface

/* src/access_map_core.sv */
// Core-side end: AHB-Lite command registers driving fetch and data checks
`timescale 1ns/100ps
module access_map_core
   import access_map_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Checker side
   access_if.core           bus
);

   logic        take;
   logic        wr_q;
   logic [7:0]  ofs_q;
   logic [31:0] hrdata_q;
   addr_t       fetch_addr_q;
   addr_t       data_addr_q;
   logic        data_write_q;
   logic        fetch_req_q;
   logic        data_req_q;
   logic        fetch_busy_q;
   logic        data_busy_q;
   logic        cmd_wr;
   logic        go_fetch;
   logic        go_data;
   logic [31:0] status;
   logic        fetch_done_q;
   logic        data_done_q;
   logic [2:0]  fetch_res_q;
   logic [2:0]  data_res_q;

   // Only whole-word transfers are expected; hsize is not decoded
   assign take     = hsel && htrans[1] && hready;
   assign cmd_wr   = wr_q && (ofs_q == CMD_OFS);
   assign go_fetch = cmd_wr && hwdata[CMD_FETCH_BIT] && !fetch_busy_q;
   assign go_data  = cmd_wr && hwdata[CMD_DATA_BIT] && !data_busy_q;

   always_comb begin
      status                = '0;
      status[ST_FETCH_DONE] = fetch_done_q;
      status[ST_FETCH_OK]   = fetch_res_q[0];
      status[ST_FETCH_ITCM] = fetch_res_q[1];
      status[ST_FETCH_CACHE] = fetch_res_q[2];
      status[ST_DATA_DONE]  = data_done_q;
      status[ST_DATA_OK]    = data_res_q[0];
      status[ST_DATA_DTCM]  = data_res_q[1];
      status[ST_DATA_IRQB]  = data_res_q[2];
      status[ST_CFG_ERROR]  = bus.cfg_error;
      status[ST_ICACHE_ON]  = bus.icache_present;
      status[ST_ICACHE_ECC] = bus.icache_protection_select;
      status[ST_FETCH_BUSY] = fetch_busy_q;
      status[ST_DATA_BUSY]  = data_busy_q;
   end

   // Address phase capture and read data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q     <= 1'b0;
         ofs_q    <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else begin
         wr_q <= take && hwrite;
         if (take) begin
            ofs_q <= {haddr[7:2], 2'b00};
         end
         if (take && !hwrite) begin
            case ({haddr[7:2], 2'b00})
               FETCH_ADDR_OFS: hrdata_q <= fetch_addr_q;
               DATA_ADDR_OFS:  hrdata_q <= data_addr_q;
               CMD_OFS:        hrdata_q <= {29'h0, data_write_q, 2'b00};
               STATUS_OFS:     hrdata_q <= status;
               default:        hrdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Address registers, written in the data phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fetch_addr_q <= ADDR_RST;
         data_addr_q  <= ADDR_RST;
         data_write_q <= 1'b0;
      end else begin
         if (wr_q && ofs_q == FETCH_ADDR_OFS) begin
            fetch_addr_q <= hwdata;
         end
         if (wr_q && ofs_q == DATA_ADDR_OFS) begin
            data_addr_q <= hwdata;
         end
         if (go_data) begin
            data_write_q <= hwdata[CMD_WRITE_BIT];
         end
      end
   end

   // Request pulses and busy tracking
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fetch_req_q  <= 1'b0;
         data_req_q   <= 1'b0;
         fetch_busy_q <= 1'b0;
         data_busy_q  <= 1'b0;
      end else begin
         fetch_req_q  <= go_fetch;
         data_req_q   <= go_data;
         fetch_busy_q <= go_fetch || (fetch_busy_q && !bus.fetch_ack);
         data_busy_q  <= go_data || (data_busy_q && !bus.data_ack);
      end
   end

   // Result capture; a new answer wins over the clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fetch_done_q <= 1'b0;
         data_done_q  <= 1'b0;
         fetch_res_q  <= 3'h0;
         data_res_q   <= 3'h0;
      end else begin
         if (bus.fetch_ack) begin
            fetch_done_q <= 1'b1;
            fetch_res_q  <= {bus.fetch_cacheable, bus.fetch_in_itcm, bus.fetch_allowed};
         end else if (go_fetch) begin
            fetch_done_q <= 1'b0;
         end
         if (bus.data_ack) begin
            data_done_q <= 1'b1;
            data_res_q  <= {bus.data_in_irq_ctrl, bus.data_in_dtcm, bus.data_allowed};
         end else if (go_data) begin
            data_done_q <= 1'b0;
         end
      end
   end

   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;
   assign hrdata         = hrdata_q;
   assign bus.fetch_req  = fetch_req_q;
   assign bus.fetch_addr = fetch_addr_q;
   assign bus.data_req   = data_req_q;
   assign bus.data_addr  = data_addr_q;
   assign bus.data_write = data_write_q;

endmodule

/* src/access_map_device.sv */
// Access window checker and memory-map decoder, device end
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
module access_map_device
   import access_map_pkg::*;
#(
   parameter logic [WIN_COUNT-1:0] FETCH_WIN_EN   = FETCH_WIN_EN_DEF,
   parameter win_word_t            FETCH_WIN_BASE = FETCH_WIN_BASE_DEF,
   parameter win_word_t            FETCH_WIN_MASK = FETCH_WIN_MASK_DEF,
   parameter logic [WIN_COUNT-1:0] DATA_WIN_EN    = DATA_WIN_EN_DEF,
   parameter win_word_t            DATA_WIN_BASE  = DATA_WIN_BASE_DEF,
   parameter win_word_t            DATA_WIN_MASK  = DATA_WIN_MASK_DEF,
   parameter logic                 ITCM_PRESENT   = ITCM_PRESENT_DEF,
   parameter region_t              ITCM_REGION    = ITCM_REGION_DEF,
   parameter offset_t              ITCM_OFFSET    = ITCM_OFFSET_DEF,
   parameter logic [9:0]           ITCM_SIZE      = ITCM_SIZE_DEF,
   parameter region_t              DTCM_REGION    = DTCM_REGION_DEF,
   parameter offset_t              DTCM_OFFSET    = DTCM_OFFSET_DEF,
   parameter logic [9:0]           DTCM_SIZE      = DTCM_SIZE_DEF,
   parameter logic                 ICACHE_PRESENT = ICACHE_PRESENT_DEF,
   parameter logic [9:0]           ICACHE_SIZE    = ICACHE_SIZE_DEF,
   parameter logic                 ICACHE_ECC     = ICACHE_ECC_DEF,
   parameter region_t              IRQB_REGION    = IRQB_REGION_DEF,
   parameter offset_t              IRQB_OFFSET    = IRQB_OFFSET_DEF,
   parameter logic [9:0]           IRQB_SIZE      = IRQB_SIZE_DEF
)(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Core side
   access_if.device  bus
);

   localparam logic [31:0] ITCM_SPAN = pow2_span(ITCM_SIZE);
   localparam logic [31:0] DTCM_SPAN = pow2_span(DTCM_SIZE);
   localparam logic [31:0] IRQB_SPAN = pow2_span(IRQB_SIZE);

   logic [WIN_COUNT-1:0] fetch_hit;
   logic [WIN_COUNT-1:0] data_hit;
   logic                 fetch_ok;
   logic                 data_ok;
   logic                 itcm_hit;
   logic                 dtcm_hit;
   logic                 irqb_hit;
   logic                 cfg_bad;

   logic fetch_ack_q;
   logic fetch_allowed_q;
   logic fetch_in_itcm_q;
   logic fetch_cacheable_q;
   logic data_ack_q;
   logic data_allowed_q;
   logic data_in_dtcm_q;
   logic data_in_irq_ctrl_q;
   logic cfg_error_q;
   logic icache_present_q;
   logic icache_ecc_q;

   // Block decode: region nibble then offset within the region
   function automatic logic block_hit(
      input addr_t       a,
      input region_t     region,
      input offset_t     ofs,
      input logic [31:0] span
   );
      offset_t keep;
      keep = ~(span[REGION_LSB-1:0] - 28'h000_0001);
      return (a[ADDR_W-1:REGION_LSB] == region) &&
             ((a[REGION_LSB-1:0] & keep) == ofs);
   endfunction

   function automatic logic win_bad(input addr_t base, input addr_t mask);
      return (base[5:0] != 6'h00) ||
             (mask[5:0] != WIN_LOW_ONES) ||
             ((mask & (mask + 32'h0000_0001)) != '0) ||
             ((base & mask) != '0);
   endfunction

   function automatic logic place_bad(input offset_t ofs, input logic [31:0] span);
      logic [32:0] end_b;
      end_b = {5'h00, ofs} + {1'b0, span};
      return ((ofs & (span[REGION_LSB-1:0] - 28'h000_0001)) != '0) ||
             (end_b > 33'h0_1000_0000);
   endfunction

   function automatic logic overlap(
      input region_t ra, input offset_t oa, input logic [31:0] sa,
      input region_t rb, input offset_t ob, input logic [31:0] sb
   );
      logic [32:0] a_end;
      logic [32:0] b_end;
      a_end = {5'h00, oa} + {1'b0, sa};
      b_end = {5'h00, ob} + {1'b0, sb};
      return (ra == rb) && ({5'h00, oa} < b_end) && ({5'h00, ob} < a_end);
   endfunction

   // Window comparators
   for (genvar i = 0; i < WIN_COUNT; i++) begin : g_win
      window_match u_fetch (
         .enable (FETCH_WIN_EN[i]),
         .base   (FETCH_WIN_BASE[i]),
         .mask   (FETCH_WIN_MASK[i]),
         .addr   (bus.fetch_addr),
         .hit    (fetch_hit[i])
      );
      window_match u_data (
         .enable (DATA_WIN_EN[i]),
         .base   (DATA_WIN_BASE[i]),
         .mask   (DATA_WIN_MASK[i]),
         .addr   (bus.data_addr),
         .hit    (data_hit[i])
      );
   end

   // With no window enabled the checker passes everything
   assign fetch_ok = (FETCH_WIN_EN == '0) || (|fetch_hit);
   assign data_ok  = (DATA_WIN_EN == '0) || (|data_hit);

   assign itcm_hit = ITCM_PRESENT &&
                     block_hit(bus.fetch_addr, ITCM_REGION, ITCM_OFFSET, ITCM_SPAN);
   assign dtcm_hit = block_hit(bus.data_addr, DTCM_REGION, DTCM_OFFSET, DTCM_SPAN);
   assign irqb_hit = block_hit(bus.data_addr, IRQB_REGION, IRQB_OFFSET, IRQB_SPAN);

   // Build-argument sanity check
   always_comb begin
      cfg_bad = 1'b0;
      for (int i = 0; i < WIN_COUNT; i++) begin
         if (FETCH_WIN_EN[i] && win_bad(FETCH_WIN_BASE[i], FETCH_WIN_MASK[i])) begin
            cfg_bad = 1'b1;
         end
         if (DATA_WIN_EN[i] && win_bad(DATA_WIN_BASE[i], DATA_WIN_MASK[i])) begin
            cfg_bad = 1'b1;
         end
      end
      case (ITCM_SIZE)
         10'd4, 10'd8, 10'd16, 10'd32, 10'd64, 10'd128, 10'd256, 10'd512: ;
         default: cfg_bad = cfg_bad | ITCM_PRESENT;
      endcase
      case (DTCM_SIZE)
         10'd4, 10'd8, 10'd16, 10'd32, 10'd48, 10'd64, 10'd128, 10'd256, 10'd512: ;
         default: cfg_bad = 1'b1;
      endcase
      case (ICACHE_SIZE)
         10'd16, 10'd32, 10'd64, 10'd128, 10'd256: ;
         default: cfg_bad = cfg_bad | ICACHE_PRESENT;
      endcase
      case (IRQB_SIZE)
         10'd32, 10'd64, 10'd128, 10'd256: ;
         default: cfg_bad = 1'b1;
      endcase
      if (ITCM_PRESENT && place_bad(ITCM_OFFSET, ITCM_SPAN)) begin
         cfg_bad = 1'b1;
      end
      if (place_bad(DTCM_OFFSET, DTCM_SPAN) || place_bad(IRQB_OFFSET, IRQB_SPAN)) begin
         cfg_bad = 1'b1;
      end
      if (overlap(DTCM_REGION, DTCM_OFFSET, DTCM_SPAN, IRQB_REGION, IRQB_OFFSET, IRQB_SPAN)) begin
         cfg_bad = 1'b1;
      end
      if (ITCM_PRESENT &&
          (overlap(ITCM_REGION, ITCM_OFFSET, ITCM_SPAN, DTCM_REGION, DTCM_OFFSET, DTCM_SPAN) ||
           overlap(ITCM_REGION, ITCM_OFFSET, ITCM_SPAN, IRQB_REGION, IRQB_OFFSET, IRQB_SPAN)))
      begin
         cfg_bad = 1'b1;
      end
   end

   // Fetch decision, one cycle after the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fetch_ack_q       <= 1'b0;
         fetch_allowed_q   <= 1'b0;
         fetch_in_itcm_q   <= 1'b0;
         fetch_cacheable_q <= 1'b0;
      end else begin
         fetch_ack_q <= bus.fetch_req;
         if (bus.fetch_req) begin
            fetch_allowed_q   <= fetch_ok;
            fetch_in_itcm_q   <= itcm_hit;
            fetch_cacheable_q <= ICACHE_PRESENT && fetch_ok && !itcm_hit;
         end
      end
   end

   // Data decision, one cycle after the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_ack_q         <= 1'b0;
         data_allowed_q     <= 1'b0;
         data_in_dtcm_q     <= 1'b0;
         data_in_irq_ctrl_q <= 1'b0;
      end else begin
         data_ack_q <= bus.data_req;
         if (bus.data_req) begin
            data_allowed_q     <= data_ok;
            data_in_dtcm_q     <= dtcm_hit;
            data_in_irq_ctrl_q <= irqb_hit;
         end
      end
   end

   // Static configuration outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_error_q      <= 1'b0;
         icache_present_q <= 1'b0;
         icache_ecc_q     <= 1'b0;
      end else begin
         cfg_error_q      <= cfg_bad;
         icache_present_q <= ICACHE_PRESENT;
         icache_ecc_q     <= ICACHE_PRESENT && ICACHE_ECC;
      end
   end

   assign bus.fetch_ack                = fetch_ack_q;
   assign bus.fetch_allowed            = fetch_allowed_q;
   assign bus.fetch_in_itcm            = fetch_in_itcm_q;
   assign bus.fetch_cacheable          = fetch_cacheable_q;
   assign bus.data_ack                 = data_ack_q;
   assign bus.data_allowed             = data_allowed_q;
   assign bus.data_in_dtcm             = data_in_dtcm_q;
   assign bus.data_in_irq_ctrl         = data_in_irq_ctrl_q;
   assign bus.cfg_error                = cfg_error_q;
   assign bus.icache_present           = icache_present_q;
   assign bus.icache_protection_select = icache_ecc_q;

endmodule

/* src/access_map_pkg.sv */
// Package: constants, types and build-time defaults of the access window and address map
// What this block does
// - Eight fetch windows, each enable/base/mask
// - Eight data windows, each enable/base/mask
// - Enable zero disables window, one activates
// - Window base low six bits zero
// - Window mask low six bits ones
// - Window mask ones contiguous from bit zero
// - Base and mask never both one
// - Blocks sit in sixteen 28-bit regions
// - Block start aligned to its size
// - Odd sizes align to next power two
// - No overlap, no region crossing
// - Start is region start plus offset
// - Optional instruction memory, 4 to 512 KB
// - Data memory 4 to 512 KB incl 48
// - Optional icache 16-256 KB, parity or ECC
// - Interrupt block placed, 32 to 256 KB
package access_map_pkg;

   localparam int WIN_COUNT   = 8;
   localparam int ADDR_W      = 32;
   localparam int REGION_LSB  = 28;
   localparam int KB_BYTES    = 1024;

   typedef logic [ADDR_W-1:0]     addr_t;
   typedef logic [3:0]            region_t;
   typedef logic [REGION_LSB-1:0] offset_t;
   typedef logic [WIN_COUNT-1:0][ADDR_W-1:0] win_word_t;

   localparam logic [5:0] WIN_LOW_ONES = 6'h3f;

   // Build-time window defaults
   localparam logic [WIN_COUNT-1:0] FETCH_WIN_EN_DEF   = 8'h01;
   localparam win_word_t            FETCH_WIN_BASE_DEF = '0;
   localparam win_word_t            FETCH_WIN_MASK_DEF =
      {{7{32'h0000_003f}}, 32'hffff_ffff};
   localparam logic [WIN_COUNT-1:0] DATA_WIN_EN_DEF    = 8'h03;
   localparam win_word_t            DATA_WIN_BASE_DEF  =
      {{6{32'h0000_0000}}, 32'h8000_0000, 32'h0000_0000};
   localparam win_word_t            DATA_WIN_MASK_DEF  =
      {{6{32'h0000_003f}}, 32'h0fff_ffff, 32'h7fff_ffff};

   // Build-time memory map defaults, sizes in KB
   localparam logic        ITCM_PRESENT_DEF  = 1'b1;
   localparam region_t     ITCM_REGION_DEF   = 4'he;
   localparam offset_t     ITCM_OFFSET_DEF   = 28'h000_0000;
   localparam logic [9:0]  ITCM_SIZE_DEF     = 10'h040;
   localparam region_t     DTCM_REGION_DEF   = 4'hf;
   localparam offset_t     DTCM_OFFSET_DEF   = 28'h004_0000;
   localparam logic [9:0]  DTCM_SIZE_DEF     = 10'h030;
   localparam logic        ICACHE_PRESENT_DEF = 1'b1;
   localparam logic [9:0]  ICACHE_SIZE_DEF   = 10'h010;
   localparam logic        ICACHE_ECC_DEF    = 1'b0;
   localparam region_t     IRQB_REGION_DEF   = 4'hf;
   localparam offset_t     IRQB_OFFSET_DEF   = 28'h0c0_0000;
   localparam logic [9:0]  IRQB_SIZE_DEF     = 10'h020;

   // Core-side command registers
   localparam logic [7:0] FETCH_ADDR_OFS = 8'h00;
   localparam logic [7:0] DATA_ADDR_OFS  = 8'h04;
   localparam logic [7:0] CMD_OFS        = 8'h08;
   localparam logic [7:0] STATUS_OFS     = 8'h0c;
   localparam int CMD_FETCH_BIT = 0;
   localparam int CMD_DATA_BIT  = 1;
   localparam int CMD_WRITE_BIT = 2;
   localparam int ST_FETCH_DONE  = 0;
   localparam int ST_FETCH_OK    = 1;
   localparam int ST_FETCH_ITCM  = 2;
   localparam int ST_FETCH_CACHE = 3;
   localparam int ST_DATA_DONE   = 4;
   localparam int ST_DATA_OK     = 5;
   localparam int ST_DATA_DTCM   = 6;
   localparam int ST_DATA_IRQB   = 7;
   localparam int ST_CFG_ERROR   = 8;
   localparam int ST_ICACHE_ON   = 9;
   localparam int ST_ICACHE_ECC  = 10;
   localparam int ST_FETCH_BUSY  = 11;
   localparam int ST_DATA_BUSY   = 12;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;

   // Power-of-two span covering a block of the given KB size
   function automatic logic [31:0] pow2_span(input logic [9:0] size_kb);
      logic [31:0] want;
      logic [31:0] span;
      want = {12'h000, size_kb, 10'h000};
      span = 32'h0000_0001;
      for (int i = 0; i < 31; i++) begin
         if (span < want) begin
            span = span << 1;
         end
      end
      return span;
   endfunction

endpackage

/* src/window_match.sv */
// One access window comparator
`timescale 1ns/100ps
module window_match
   import access_map_pkg::*;
(
   // Window setting
   input  wire logic  enable,
   input  wire addr_t base,
   input  wire addr_t mask,
   // Address and result
   input  wire addr_t addr,
   output logic       hit
);
   assign hit = enable && ((addr | mask) == (base | mask));
endmodule
